// ### design/branch_increment_or_exec.sv
// Executor for jump, increment(-skip) and literal-OR with an APB register file
//
// Behaviour
// - Jump loads 11-bit immediate into low PC
// - Jump fills PC upper bits from page latch
// - Jump is one word, two cycles
// - Increment-skip adds one, routes by destination bit
// - Zero result flushes next instruction as no-op
// - Plain increment routes sum, updates zero, one cycle
// - Literal-OR into accumulator, updates zero, one cycle
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module branch_increment_or_exec
#(
	parameter int FILE_DEPTH = 128
)
(
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [exec_pkg::ADDR_W-1:0] paddr,
	input  wire logic [exec_pkg::DATA_W-1:0] pwdata,
	output var  logic [exec_pkg::DATA_W-1:0] prdata,
	output var  logic                        pready,
	output var  logic                        pslverr
);
	import exec_pkg::*;

	// Elaboration check: the file index is seven bits wide
	if (FILE_DEPTH != 128)
	begin : g_bad_depth
		$error("FILE_DEPTH must be 128");
	end

	////////////////////////////////////////////////////////////////////////
	// State
	exec_state_e          state;
	exec_state_e          next_state;
	logic [INSTR_W-1:0]   instr;
	logic [7:0]           acc;
	logic [PAGE_W-1:0]    page_latch;
	logic [PC_W-1:0]      pc;
	logic                 zero;
	logic [31:0]          cycles;
	logic [7:0]           file_mem [FILE_DEPTH];

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire                  xfer      = psel & penable & pready;
	wire                  wr        = xfer & pwrite;
	wire                  idle      = (state == ST_IDLE);
	wire                  sel_file  = (paddr[FILE_WIN_HI:FILE_WIN_LO] == FILE_WIN_SEL);
	wire [FIDX_HI:0]      file_idx  = paddr[FIDX_ADDR_HI:FIDX_ADDR_LO];
	wire                  wr_instr  = wr & (paddr == OFS_INSTR);
	wire                  wr_acc    = wr & (paddr == OFS_ACC);
	wire                  wr_page   = wr & (paddr == OFS_PAGE);
	wire                  wr_pc     = wr & (paddr == OFS_PC);
	wire                  wr_status = wr & (paddr == OFS_STATUS);
	wire                  wr_file   = wr & sel_file;

	////////////////////////////////////////////////////////////////////////
	// Instruction decode and datapath
	wire                  is_jump   = (instr[OPC_HI:JUMP_OPC_LO] == OPC_JUMP);
	wire                  is_incs   = (instr[OPC_HI:OPC_LO] == OPC_INC_SKIP);
	wire                  is_increment_file   = (instr[OPC_HI:OPC_LO] == OPC_INC_FILE);
	wire                  is_or     = (instr[OPC_HI:OPC_LO] == OPC_OR_LIT);
	wire                  to_file   = instr[DEST_BIT];
	wire [7:0]            fval      = file_mem[instr[FIDX_HI:0]];
	wire [7:0]            inc_sum   = fval + 8'h01;                 // Wraps 0xFF to 0x00
	wire [7:0]            or_res    = acc | instr[LIT_HI:0];
	wire                  exec      = (state == ST_EXEC);
	wire                  do_inc    = exec & (is_incs | is_increment_file);
	wire                  skip      = exec & is_incs & (inc_sum == 8'h00);
	wire [PC_W-1:0]       pc_inc    = pc + 13'h0001;
	wire [1:0]            page_bits = page_latch[PAGE_SEL_HI:PAGE_SEL_LO];
	wire [PC_W-1:0]       jump_pc   = {page_bits, instr[JUMP_K_W-1:0]};

	////////////////////////////////////////////////////////////////////////
	// Sequencer: jump and taken skip spend a second cycle on a no-op
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:  next_state = wr_instr ? ST_EXEC : ST_IDLE;
			ST_EXEC:  next_state = (is_jump | skip) ? ST_FLUSH : ST_IDLE;
			ST_FLUSH: next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Instruction latch; issue only lands while idle since busy stalls the bus
	always_ff @(posedge core_clk)
	begin
		if (rst)
			instr <= INSTR_RST;
		else if (wr_instr)
			instr <= pwdata[INSTR_W-1:0];
	end

	// Program counter; the flushed slot still advances past the skipped word
	always_ff @(posedge core_clk)
	begin
		if (rst)
			pc <= PC_RST;
		else if (exec && is_jump)
			pc <= jump_pc;
		else if (exec || (state == ST_FLUSH && is_incs))
			pc <= pc_inc;
		else if (wr_pc)
			pc <= pwdata[PC_W-1:0];
	end

	// Accumulator
	always_ff @(posedge core_clk)
	begin
		if (rst)
			acc <= ACC_RST;
		else if (exec && is_or)
			acc <= or_res;
		else if (do_inc && !to_file)
			acc <= inc_sum;
		else if (wr_acc)
			acc <= pwdata[7:0];
	end

	// Zero flag: hardware update wins over a software write
	always_ff @(posedge core_clk)
	begin
		if (rst)
			zero <= 1'b0;
		else if (exec && is_or)
			zero <= (or_res == 8'h00);
		else if (exec && is_increment_file)
			zero <= (inc_sum == 8'h00);
		else if (wr_status)
			zero <= pwdata[STAT_ZERO_BIT];
	end

	// Page latch and cycle counter
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			page_latch <= PAGE_RST;
			cycles     <= 32'h0000_0000;
		end
		else
		begin
			if (wr_page)
				page_latch <= pwdata[PAGE_W-1:0];
			if (!idle)
				cycles <= cycles + 32'h0000_0001;
		end
	end

	// File registers: execution and bus never write in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (do_inc && to_file)
			file_mem[instr[FIDX_HI:0]] <= inc_sum;
		else if (wr_file)
			file_mem[file_idx] <= pwdata[7:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets answer zero with an error
	logic [DATA_W-1:0] next_prdata;
	logic              next_err;
	always_comb
	begin
		next_prdata = '0;
		next_err    = 1'b0;
		if (paddr == OFS_INSTR)
			next_prdata[INSTR_W-1:0] = instr;
		else if (paddr == OFS_ACC)
			next_prdata[7:0] = acc;
		else if (paddr == OFS_PAGE)
			next_prdata[PAGE_W-1:0] = page_latch;
		else if (paddr == OFS_PC)
			next_prdata[PC_W-1:0] = pc;
		else if (paddr == OFS_STATUS)
		begin
			next_prdata[STAT_ZERO_BIT] = zero;
			next_prdata[STAT_BUSY_BIT] = !idle;
		end
		else if (paddr == OFS_CYCLES)
			next_prdata = cycles;
		else if (sel_file)
			next_prdata[7:0] = file_mem[file_idx];
		else
			next_err = 1'b1;
	end

	// Registered answer, held back while an instruction is running
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & penable & !pready & idle;
			prdata  <= next_prdata;
			pslverr <= next_err;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_flush_then_idle;
		(state == ST_FLUSH) ##1 (state == ST_IDLE);
	endsequence

	sequence s_jump_exec;
		exec && is_jump;
	endsequence

	property p_jump_low;
		s_jump_exec |=> (pc[10:0] == $past(instr[10:0]));
	endproperty
	a_jump_low: assert property (p_jump_low) else $error("jump low pc wrong");

	property p_jump_high;
		s_jump_exec |=> (pc[12:11] == $past(page_latch[4:3]));
	endproperty
	a_jump_high: assert property (p_jump_high) else $error("jump page bits wrong");

	property p_jump_two;
		s_jump_exec |=> s_flush_then_idle;
	endproperty
	a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

	property p_incs_dest;
		exec && is_incs |=> (to_file ? (file_mem[$past(instr[6:0])] == $past(inc_sum))
		                             : (acc == $past(inc_sum)));
	endproperty
	a_incs_dest: assert property (p_incs_dest) else $error("inc-skip dest wrong");

	property p_skip;
		exec && is_incs && (fval == 8'hFF) |=> s_flush_then_idle ##0 (pc == $past(pc, 2) + 13'h0002);
	endproperty
	a_skip: assert property (p_skip) else $error("skip not taken");

	property p_noskip;
		exec && is_incs && (fval != 8'hFF) |=> (state == ST_IDLE);
	endproperty
	a_noskip: assert property (p_noskip) else $error("skip taken wrongly");

	property p_increment_file;
		exec && is_increment_file |=> (state == ST_IDLE) && (zero == ($past(fval) == 8'hFF));
	endproperty
	a_increment_file: assert property (p_increment_file) else $error("increment wrong");

	property p_or;
		exec && is_or |=> (acc == ($past(acc) | $past(instr[7:0]))) && (state == ST_IDLE);
	endproperty
	a_or: assert property (p_or) else $error("literal OR wrong");

	property p_or_zero;
		exec && is_or |=> (zero == (acc == 8'h00));
	endproperty
	a_or_zero: assert property (p_or_zero) else $error("zero flag wrong");

endmodule // branch_increment_or_exec
`default_nettype wire

// ### design/exec_pkg.sv
// Shared constants for the jump, increment and literal-OR executor
package exec_pkg;
	// Bus geometry
	localparam int               ADDR_W        = 12;
	localparam int               DATA_W        = 32;
	// Register byte offsets
	localparam logic [11:0]      OFS_INSTR     = 12'h000;
	localparam logic [11:0]      OFS_ACC       = 12'h004;
	localparam logic [11:0]      OFS_PAGE      = 12'h008;
	localparam logic [11:0]      OFS_PC        = 12'h00C;
	localparam logic [11:0]      OFS_STATUS    = 12'h010;
	localparam logic [11:0]      OFS_CYCLES    = 12'h014;
	// File window: 0x200..0x3FC, one word per file register
	localparam logic [2:0]       FILE_WIN_SEL  = 3'h1;
	localparam int               FILE_WIN_HI   = 11;
	localparam int               FILE_WIN_LO   = 9;
	// Field layouts
	localparam int               INSTR_W       = 14;
	localparam int               PC_W          = 13;
	localparam int               PAGE_W        = 5;
	localparam int               JUMP_K_W      = 11;
	localparam int               STAT_ZERO_BIT = 0;
	localparam int               STAT_BUSY_BIT = 1;
	localparam int               DEST_BIT      = 7;
	localparam int               OPC_HI        = 13;
	localparam int               JUMP_OPC_LO   = 11;
	localparam int               OPC_LO        = 8;
	localparam int               LIT_HI        = 7;
	localparam int               FIDX_HI       = 6;
	localparam int               FIDX_ADDR_HI  = 8;
	localparam int               FIDX_ADDR_LO  = 2;
	localparam int               PAGE_SEL_HI   = 4;
	localparam int               PAGE_SEL_LO   = 3;
	// Opcode patterns
	localparam logic [2:0]       OPC_JUMP      = 3'h5;
	localparam logic [5:0]       OPC_INC_SKIP  = 6'h0F;
	localparam logic [5:0]       OPC_INC_FILE  = 6'h0A;
	localparam logic [5:0]       OPC_OR_LIT    = 6'h38;
	// Reset values
	localparam logic [7:0]       ACC_RST       = 8'h00;
	localparam logic [PC_W-1:0]  PC_RST        = 13'h0000;
	localparam logic [4:0]       PAGE_RST      = 5'h00;
	localparam logic [13:0]      INSTR_RST     = 14'h0000;
	// Executor states
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_FLUSH = 3'b100
	} exec_state_e;
endpackage : exec_pkg

// ### sim/tb_top.sv
// Self-checking bench for the jump, increment and literal-OR executor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import exec_pkg::*;
	logic                core_clk = 1'b0;
	logic                rst      = 1'b1;
	logic                psel     = 1'b0;
	logic                penable  = 1'b0;
	logic                pwrite   = 1'b0;
	logic [ADDR_W-1:0]   paddr    = '0;
	logic [DATA_W-1:0]   pwdata   = '0;
	logic [DATA_W-1:0]   prdata;
	logic                pready;
	logic                pslverr;
	int                  num_errors = 0;
	int                  checks     = 0;
	int                  i;
	logic [32:0]         expq[$];
	logic [32:0]         seen;
	logic [PC_W-1:0]     ep;
	logic [31:0]         ec;
	logic [7:0]          v, a, k8, r;
	logic                d, sk, zp;
	logic [6:0]          f;
	logic [4:0]          pg;
	logic [10:0]         k;

	////////////////////////////////////////////////////////////////////////////
	// Clock and device
	always #20 core_clk = ~core_clk;

	branch_increment_or_exec #(.FILE_DEPTH(128)) uut
	(
		.core_clk (core_clk),
		.rst      (rst),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Closing and watchdog
	task automatic finish_test();
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Whole run is a few hundred cycles; this is generous
	initial
	begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// Read monitor: oldest note is matched at the completing edge
	always @(posedge core_clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			seen = {pslverr, prdata};
			checks++;
			if (expq.size() == 0 || seen !== expq[0])
			begin
				num_errors++;
				$display("unexpected read %h: expected %h seen %h", paddr,
					(expq.size() == 0) ? 33'h0 : expq[0], seen);
			end
			if (expq.size() != 0)
				void'(expq.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus tasks; slave may stall while an instruction runs, so no fixed wait
	task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] dt);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= dt;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
		xfer(1'b1, ad, dt);
	endtask

	task automatic rd(input logic [11:0] ad, input logic err, input logic [31:0] e);
		expq.push_back({err, e});
		xfer(1'b0, ad, 32'h0000_0000);
	endtask

	// Issue one instruction, then check program counter and cycle count
	task automatic issue(input logic [13:0] ins, input logic [PC_W-1:0] npc, input int cyc);
		wr(OFS_INSTR, {18'h0, ins});
		ep = npc;
		ec = ec + cyc;
		rd(OFS_PC, 1'b0, {19'h0, ep});
		rd(OFS_CYCLES, 1'b0, ec);
	endtask

	function automatic logic [11:0] fa(input logic [6:0] idx);
		return 12'h200 + {3'h0, idx, 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		void'($urandom(32'hEB5731C9));
		ep = '0;
		ec = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd(OFS_ACC, 1'b0, 32'h0);
		rd(OFS_PAGE, 1'b0, 32'h0);
		rd(OFS_PC, 1'b0, 32'h0);
		rd(OFS_STATUS, 1'b0, 32'h0);
		rd(OFS_CYCLES, 1'b0, 32'h0);
		// Unmapped place answers with an error and no data
		rd(12'h100, 1'b1, 32'h0);
		// Jumps with random page and target
		for (i = 0; i < 4; i++)
		begin
			pg = $urandom;
			k  = $urandom;
			wr(OFS_PAGE, {27'h0, pg});
			issue({OPC_JUMP, k}, {pg[4:3], k}, 2);
		end
		// Both increments, both destinations, wrap to zero first
		for (i = 0; i < 8; i++)
		begin
			v  = (i < 4) ? 8'hFF : $urandom;
			d  = i[0];
			sk = i[1];
			f  = $urandom;
			a  = $urandom;
			r  = v + 8'h01;
			zp = sk ? $urandom : (r != 8'h00);
			wr(fa(f), {24'h0, v});
			wr(OFS_ACC, {24'h0, a});
			wr(OFS_STATUS, {31'h0, zp});
			if (sk && r == 8'h00)
				issue({OPC_INC_SKIP, d, f}, ep + 13'h2, 2);
			else
				issue({sk ? OPC_INC_SKIP : OPC_INC_FILE, d, f}, ep + 13'h1, 1);
			rd(OFS_ACC, 1'b0, {24'h0, d ? a : r});
			rd(fa(f), 1'b0, {24'h0, d ? r : v});
			rd(OFS_STATUS, 1'b0, {31'h0, sk ? zp : (r == 8'h00)});
		end
		// Literal OR, first case all zeros
		for (i = 0; i < 6; i++)
		begin
			a  = (i == 0) ? 8'h00 : $urandom;
			k8 = (i == 0) ? 8'h00 : $urandom;
			wr(OFS_ACC, {24'h0, a});
			wr(OFS_STATUS, {31'h0, (a | k8) != 8'h00});
			issue({OPC_OR_LIT, k8}, ep + 13'h1, 1);
			rd(OFS_ACC, 1'b0, {24'h0, a | k8});
			rd(OFS_STATUS, 1'b0, {31'h0, (a | k8) == 8'h00});
		end
		repeat (3) @(posedge core_clk);
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
